// ### supervisor_watchdog_reset_map.svh
// Constants and timing counts for the reset supervisor with watchdog
`ifndef SUPERVISOR_WATCHDOG_RESET_MAP_SVH
`define SUPERVISOR_WATCHDOG_RESET_MAP_SVH

`define CLK_PERIOD_PS 4000
`define GLITCH_REJECT_NS 100
`define GLITCH_REJECT_CYC ((`GLITCH_REJECT_NS * 1000) / `CLK_PERIOD_PS)
`define MANUAL_QUALIFY_US 1
`define MANUAL_QUALIFY_CYC \
  ((`MANUAL_QUALIFY_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STROBE_MIN_NS 50
`define STROBE_MIN_CYC \
  ((`STROBE_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESET_PULSE_MS 140
`define RESET_PULSE_CYC 35000000
`define WATCHDOG_TIMEOUT_MS 1600
`define WATCHDOG_TIMEOUT_CYC 400000000
`define DEBOUNCE_CYC 32
`define CNT_W 32
`define DB_W 8

`endif

// ### supervisor_watchdog_reset_pkg.sv
// Types shared by the reset supervisor
package supervisor_watchdog_reset_pkg;
  typedef enum logic [1:0] {
    RST_IDLE,
    RST_HOLD,
    RST_STRETCH
  } reset_state_type;

  typedef struct packed {
    logic undervoltage;
    logic manual_low;
    logic watchdog_expired;
  } reset_cause_type;
endpackage

// ### supervisor_watchdog_reset.sv
// Reset supervisor: debounced manual reset, watchdog and pulse stretcher
`include "supervisor_watchdog_reset_map.svh"
`timescale 1ns/100ps
`default_nettype none
module supervisor_watchdog_reset #(
  parameter logic [`CNT_W-1:0] RESET_PULSE_CYCLES = `RESET_PULSE_CYC,
  parameter logic [`CNT_W-1:0] WATCHDOG_TIMEOUT_CYCLES = `WATCHDOG_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic undervoltage_in,
  input wire logic manual_reset_n_input,
  input wire logic watchdog_strobe_input,
  input wire logic watchdog_strobe_float,
  output logic reset_n_out,
  output logic reset_out,
  output supervisor_watchdog_reset_pkg::reset_cause_type reset_cause
);

  localparam logic [`DB_W-1:0] DB_LIMIT = `DB_W'(`DEBOUNCE_CYC);
  localparam logic [`DB_W-1:0] GLITCH_CYC = `DB_W'(`GLITCH_REJECT_CYC);
  // Saturation value of the low-run helper counter
  localparam logic [`DB_W-1:0] RUN_MAX = {`DB_W{1'b1}};
  // Idle levels: manual input high, strobe low, no undervoltage; clearing
  // the chain to them keeps a false strobe edge out of the first cycles
  localparam logic [3:0] SYNC_IDLE = 4'h2;

  // True while the state machine rests with reset released
  function automatic logic is_idle(
    input supervisor_watchdog_reset_pkg::reset_state_type st
  );
    return st == supervisor_watchdog_reset_pkg::RST_IDLE;
  endfunction

  // Two-flop synchronisers for every asynchronous input
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  wire logic [3:0] raw_in = {watchdog_strobe_float, watchdog_strobe_input,
                             manual_reset_n_input, undervoltage_in};
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end
  wire logic uv_s = sync2_q[0];
  wire logic manual_n_s = sync2_q[1];
  wire logic strobe_s = sync2_q[2];
  wire logic float_s = sync2_q[3];

  // Manual reset filter: level must hold past the glitch width and the
  // debounce window before the filtered state follows it.
  logic manual_filt_n_q;
  logic [`DB_W-1:0] db_cnt_q;
  logic [`DB_W-1:0] db_cnt_d;
  wire logic manual_differs = (manual_n_s != manual_filt_n_q);
  wire logic [`DB_W-1:0] db_need = (DB_LIMIT > GLITCH_CYC) ? DB_LIMIT
                                   : GLITCH_CYC + `DB_W'(1);
  wire logic db_done = manual_differs && (db_cnt_q >= db_need - `DB_W'(1));
  assign db_cnt_d = (!manual_differs || db_done) ? '0
                  : db_cnt_q + `DB_W'(1);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      manual_filt_n_q <= 1'b1;
      db_cnt_q <= '0;
    end else begin
      db_cnt_q <= db_cnt_d;
      if (db_done) begin
        manual_filt_n_q <= manual_n_s;
      end
    end
  end

  // Length of the present low run on the synchronised manual input,
  // saturating so that a long press cannot wrap to a short count
  logic [`DB_W-1:0] low_run_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      low_run_q <= '0;
    end else if (manual_n_s) begin
      low_run_q <= '0;
    end else if (low_run_q != RUN_MAX) begin
      low_run_q <= low_run_q + `DB_W'(1);
    end
  end

  // Strobe edge detection on the synchronised level
  logic strobe_prev_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_s;
    end
  end
  wire logic strobe_edge = (strobe_s != strobe_prev_q);

  // Reset state and watchdog counter
  supervisor_watchdog_reset_pkg::reset_state_type state_q;
  supervisor_watchdog_reset_pkg::reset_state_type state_d;
  logic [`CNT_W-1:0] wd_cnt_q;
  logic [`CNT_W-1:0] wd_cnt_d;
  logic [`CNT_W-1:0] rp_cnt_q;
  logic [`CNT_W-1:0] rp_cnt_d;
  logic reset_q;
  supervisor_watchdog_reset_pkg::reset_cause_type cause_q;

  wire logic hold_src = uv_s || !manual_filt_n_q;
  wire logic wd_expired = (wd_cnt_q >= WATCHDOG_TIMEOUT_CYCLES - `CNT_W'(1));
  // A floating strobe leaves the counter running but cannot cause reset
  wire logic wd_fire = wd_expired && !float_s &&
                       is_idle(state_q);
  wire logic rp_done = (rp_cnt_q >= RESET_PULSE_CYCLES - `CNT_W'(1));

  always_comb begin
    state_d = state_q;
    rp_cnt_d = '0;
    case (state_q)
      supervisor_watchdog_reset_pkg::RST_IDLE: begin
        if (hold_src) begin
          state_d = supervisor_watchdog_reset_pkg::RST_HOLD;
        end else if (wd_fire) begin
          state_d = supervisor_watchdog_reset_pkg::RST_STRETCH;
        end
      end
      supervisor_watchdog_reset_pkg::RST_HOLD: begin
        if (!hold_src) begin
          state_d = supervisor_watchdog_reset_pkg::RST_STRETCH;
        end
      end
      supervisor_watchdog_reset_pkg::RST_STRETCH: begin
        if (hold_src) begin
          state_d = supervisor_watchdog_reset_pkg::RST_HOLD;
        end else if (rp_done) begin
          state_d = supervisor_watchdog_reset_pkg::RST_IDLE;
        end else begin
          rp_cnt_d = rp_cnt_q + `CNT_W'(1);
        end
      end
      default: begin
        state_d = supervisor_watchdog_reset_pkg::RST_HOLD;
      end
    endcase
  end

  wire logic reset_d = !is_idle(state_d);
  // Counter is cleared by edges and held at zero through reset
  assign wd_cnt_d = (reset_d || reset_q || strobe_edge) ? '0
                  : (wd_expired ? wd_cnt_q : wd_cnt_q + `CNT_W'(1));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= supervisor_watchdog_reset_pkg::RST_HOLD;
      rp_cnt_q <= '0;
      wd_cnt_q <= '0;
      reset_q <= 1'b1;
      cause_q <= '0;
    end else begin
      state_q <= state_d;
      rp_cnt_q <= rp_cnt_d;
      wd_cnt_q <= wd_cnt_d;
      reset_q <= reset_d;
      cause_q.undervoltage <= uv_s;
      cause_q.manual_low <= !manual_filt_n_q;
      cause_q.watchdog_expired <= wd_fire ? 1'b1
                                : (reset_d ? cause_q.watchdog_expired : 1'b0);
    end
  end

  // Cycles spent in the stretch state; only the release check reads it,
  // so the pulse length is judged apart from the pulse counter itself
  logic [`CNT_W-1:0] stretch_len_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stretch_len_q <= '0;
    end else if (state_q == supervisor_watchdog_reset_pkg::RST_STRETCH) begin
      stretch_len_q <= stretch_len_q + `CNT_W'(1);
    end else begin
      stretch_len_q <= '0;
    end
  end

  assign reset_out = reset_q;
  assign reset_n_out = !reset_q;
  assign reset_cause = cause_q;

  a_outputs_complement: assert property (@(posedge mclk)
    reset_out == !reset_n_out)
    else $error("reset outputs not complementary");

  a_hold_src_resets: assert property (@(posedge mclk) disable iff (sys_rst)
    hold_src |=> reset_q)
    else $error("reset not asserted while source active");

  a_counter_zero_reset: assert property (@(posedge mclk)
    disable iff (sys_rst) reset_q |=> wd_cnt_q == '0)
    else $error("watchdog counter not held during reset");

  a_edge_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    strobe_edge |=> wd_cnt_q == '0)
    else $error("strobe edge did not clear counter");

  a_wd_fire_reset: assert property (@(posedge mclk)
    disable iff (sys_rst) wd_fire && !hold_src |=> reset_q && state_q ==
      supervisor_watchdog_reset_pkg::RST_STRETCH)
    else $error("watchdog expiry did not assert reset");

  a_float_no_fire: assert property (@(posedge mclk)
    disable iff (sys_rst) float_s |-> !wd_fire)
    else $error("watchdog fired while strobe floating");

  a_glitch_ignored: assert property (@(posedge mclk)
    disable iff (sys_rst)
    $fell(manual_filt_n_q) |-> $past(manual_n_s, 2) == 1'b0)
    else $error("short manual reset pulse accepted");

  a_stretch_release: assert property (@(posedge mclk)
    disable iff (sys_rst) $fell(reset_q) |-> $past(rp_done) && !$past(hold_src))
    else $error("reset released before pulse period");

  a_sync_chain: assert property (@(posedge mclk) disable iff (sys_rst)
    sync2_q == $past(sync1_q))
    else $error("synchroniser chain broken");

  // Checks on the filter, the edge detector, the counters, the state walk and the reset causes
  a_uv_clears_counter: assert property (@(posedge mclk)
    disable iff (sys_rst) hold_src |=> wd_cnt_q == '0)
    else $error("watchdog counter not cleared by reset source");

  a_pulse_length: assert property (@(posedge mclk)
    disable iff (sys_rst) $fell(reset_q) |-> stretch_len_q >= RESET_PULSE_CYCLES)
    else $error("reset pulse shorter than pulse period");

  a_glitch_length: assert property (@(posedge mclk)
    disable iff (sys_rst) $fell(manual_filt_n_q) |-> low_run_q > GLITCH_CYC)
    else $error("manual low accepted within glitch width");

  a_filter_follows: assert property (@(posedge mclk)
    disable iff (sys_rst) db_done |=> manual_filt_n_q == $past(manual_n_s))
    else $error("filtered manual level not updated");

  a_debounce_hold: assert property (@(posedge mclk)
    disable iff (sys_rst) manual_differs && !db_done |=> $stable(manual_filt_n_q))
    else $error("filtered manual level moved during debounce");

  a_manual_release: assert property (@(posedge mclk)
    disable iff (sys_rst) $rose(manual_filt_n_q) && !uv_s |=>
      state_q == supervisor_watchdog_reset_pkg::RST_STRETCH)
    else $error("manual release did not start the stretch");

  a_rp_idle_zero: assert property (@(posedge mclk)
    disable iff (sys_rst)
    state_q != supervisor_watchdog_reset_pkg::RST_STRETCH |-> rp_cnt_q == '0)
    else $error("pulse counter not cleared outside stretch");

  a_stretch_counts: assert property (@(posedge mclk)
    disable iff (sys_rst)
    state_q == supervisor_watchdog_reset_pkg::RST_STRETCH && !hold_src &&
      !rp_done |=> rp_cnt_q == $past(rp_cnt_q) + `CNT_W'(1))
    else $error("pulse counter did not advance");

  a_counter_counts: assert property (@(posedge mclk)
    disable iff (sys_rst) is_idle(state_q) && !hold_src && !wd_expired &&
      !strobe_edge |=> wd_cnt_q == $past(wd_cnt_q) + `CNT_W'(1))
    else $error("watchdog counter did not advance");

  a_float_holds: assert property (@(posedge mclk)
    disable iff (sys_rst) is_idle(state_q) && float_s && !hold_src &&
      wd_expired && !strobe_edge |=> $stable(wd_cnt_q) && !reset_q)
    else $error("floating strobe let watchdog reset through");

  a_edge_seen: assert property (@(posedge mclk)
    disable iff (sys_rst) $changed(strobe_s) |-> strobe_edge)
    else $error("strobe transition not detected");

  a_state_output: assert property (@(posedge mclk)
    disable iff (sys_rst) reset_q == !is_idle(state_q))
    else $error("reset output disagrees with state");

  a_cause_watchdog: assert property (@(posedge mclk)
    disable iff (sys_rst) wd_fire |=> reset_cause.watchdog_expired)
    else $error("watchdog cause not reported");

  a_cause_manual: assert property (@(posedge mclk)
    disable iff (sys_rst) !manual_filt_n_q |=> reset_cause.manual_low)
    else $error("manual cause not reported");

  a_cause_uv: assert property (@(posedge mclk)
    disable iff (sys_rst) uv_s |=> reset_cause.undervoltage)
    else $error("undervoltage cause not reported");

  a_hold_stays: assert property (@(posedge mclk)
    disable iff (sys_rst) state_q == supervisor_watchdog_reset_pkg::RST_HOLD &&
      hold_src |=> state_q == supervisor_watchdog_reset_pkg::RST_HOLD)
    else $error("hold left while source active");

  a_hold_to_stretch: assert property (@(posedge mclk)
    disable iff (sys_rst) state_q == supervisor_watchdog_reset_pkg::RST_HOLD &&
      !hold_src |=> state_q == supervisor_watchdog_reset_pkg::RST_STRETCH &&
      rp_cnt_q == '0)
    else $error("stretch not started from zero");

  a_stretch_rehold: assert property (@(posedge mclk)
    disable iff (sys_rst)
    state_q == supervisor_watchdog_reset_pkg::RST_STRETCH && hold_src |=>
      state_q == supervisor_watchdog_reset_pkg::RST_HOLD)
    else $error("source during stretch did not return to hold");

endmodule
`default_nettype wire

// ### strobe_host.sv
// Processor model that services the watchdog strobe
`timescale 1ns/100ps
`default_nettype none
module strobe_host (
  input wire logic mclk,
  input wire logic run,
  input wire logic [7:0] gap,
  input wire logic [7:0] width,
  output logic strobe
);
  logic [7:0] cnt_q = 8'h00;
  initial strobe = 1'b0;
  // High for width cycles in each period of gap+1 cycles, then back low
  always @(negedge mclk) begin
    cnt_q <= (run && cnt_q < gap) ? cnt_q + 8'h01 : 8'h00;
    strobe <= run && (cnt_q < width);
  end
endmodule
`default_nettype wire

// ### test_supervisor_watchdog_reset.sv
// Self-checking bench for the reset supervisor
`timescale 1ns/100ps
`default_nettype none
module test_supervisor_watchdog_reset;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic uv = 1'b0;
  logic manual_n = 1'b1;
  logic flt = 1'b0;
  logic run = 1'b1;
  logic [7:0] gap = 8'h4F;
  logic [7:0] wid = 8'h28;
  logic strobe, rst_n, rst;
  supervisor_watchdog_reset_pkg::reset_cause_type cause;
  int mismatches = 0;
  int samples_checked = 0;
  int n;
  always #2 mclk = ~mclk;
  strobe_host strobe_host_i (.mclk(mclk), .run(run), .gap(gap),
    .width(wid), .strobe(strobe));
  // Short counts keep the run brief
  supervisor_watchdog_reset #(.RESET_PULSE_CYCLES(32'h14),
    .WATCHDOG_TIMEOUT_CYCLES(32'h32)) supervisor_watchdog_reset_i (
    .mclk(mclk), .sys_rst(sys_rst), .undervoltage_in(uv),
    .manual_reset_n_input(manual_n), .watchdog_strobe_input(strobe),
    .watchdog_strobe_float(flt), .reset_n_out(rst_n), .reset_out(rst),
    .reset_cause(cause));
  task summarize();
    $display("mismatches=%0d samples_checked=%0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // A bound that runs out ends the run
  task wait_rst(input logic v, input int lim, output int c);
    c = 0;
    while (rst !== v && c < lim) begin
      @(negedge mclk);
      c++;
    end
    check(rst === v, "reset wait timed out");
    if (rst !== v) summarize();
  endtask
  task quiet(input int cyc, input string msg);
    int hi;
    hi = 0;
    repeat (cyc) begin
      @(negedge mclk);
      if (rst !== 1'b0 || rst_n !== 1'b1) hi++;
    end
    check(hi == 0, msg);
  endtask
  task t_release();
    check(rst === 1'b1 && rst_n === 1'b0, "no reset at start");
    wait_rst(1'b0, 40, n);
    check(n >= 20, "start pulse short");
  endtask
  task t_uv();
    uv = 1'b1;
    wait_rst(1'b1, 8, n);
    check(cause.undervoltage === 1'b1, "uv cause");
    check(rst_n === 1'b0, "low output not asserted");
    repeat (40) @(negedge mclk);
    uv = 1'b0;
    wait_rst(1'b0, 40, n);
    check(n >= 20, "uv stretch short");
  endtask
  task t_glitch();
    manual_n = 1'b0;
    repeat (25) @(negedge mclk);
    manual_n = 1'b1;
    quiet(60, "glitch caused reset");
  endtask
  task t_manual();
    repeat (3) begin
      manual_n = 1'b0;
      repeat (4) @(negedge mclk);
      manual_n = 1'b1;
      repeat (4) @(negedge mclk);
    end
    manual_n = 1'b0;
    wait_rst(1'b1, 45, n);
    check(cause.manual_low === 1'b1, "manual cause");
    repeat (250) @(negedge mclk);
    check(rst === 1'b1, "reset dropped while held");
    manual_n = 1'b1;
    wait_rst(1'b0, 70, n);
    check(n >= 20, "manual stretch short");
  endtask
  task t_service(input logic [7:0] g, input logic [7:0] w);
    gap = g;
    wid = w;
    quiet(200, "serviced strobe reset");
  endtask
  task t_timeout();
    run = 1'b0;
    wait_rst(1'b1, 70, n);
    check(cause.watchdog_expired === 1'b1, "watchdog cause");
    wait_rst(1'b0, 30, n);
    check(n >= 18, "watchdog stretch short");
    wait_rst(1'b1, 70, n);
    check(n >= 45, "counter not held in reset");
    wait_rst(1'b0, 30, n);
  endtask
  task t_float();
    flt = 1'b1;
    quiet(150, "floating strobe reset");
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    t_release();
    t_uv();
    t_glitch();
    t_manual();
    t_service(8'h4F, 8'h28);
    t_service(8'h2D, 8'h0D);
    t_timeout();
    t_float();
    summarize();
  end
endmodule
`default_nettype wire
